//--- rtl/mlsd_decode.sv
// Purpose: Package and opcode decoder for the move, load and stack group
// Assumes: Opcode is stable while i_start is high
// Notes: Register field code 110 selects memory; slot 110 holds the flags
`timescale 1ns/10ps
`default_nettype none

package mlsd_pkg;
	typedef enum logic [3:0] {
		K_NONE, K_COPY, K_MEMRD, K_MEMWR, K_LDPAIR, K_LDSP,
		K_SWAPDH, K_PUSH, K_POP, K_SWAPSTK, K_HLTOSP
	} mlsd_kind_t;
	typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} mlsd_state_t;
	localparam logic [2:0] REG_B = 3'h0;
	localparam logic [2:0] REG_C = 3'h1;
	localparam logic [2:0] REG_D = 3'h2;
	localparam logic [2:0] REG_E = 3'h3;
	localparam logic [2:0] REG_H = 3'h4;
	localparam logic [2:0] REG_L = 3'h5;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_FLAGS = 3'h6;
	localparam logic [2:0] REG_A = 3'h7;
	localparam logic [1:0] PAIR_SP_AF = 2'h3;
	localparam logic [7:0] OP_HALT = 8'h76;
	localparam logic [7:0] OP_SWAPDH = 8'hEB;
	localparam logic [7:0] OP_SWAPSTK = 8'hE3;
	localparam logic [7:0] OP_HLTOSP = 8'hF9;
	localparam logic [4:0] CYC_COPY = 5'h04;
	localparam logic [4:0] CYC_MEM = 5'h07;
	localparam logic [4:0] CYC_LOAD16 = 5'h0A;
	localparam logic [4:0] CYC_SWAPDH = 5'h04;
	localparam logic [4:0] CYC_PUSH = 5'h0C;
	localparam logic [4:0] CYC_POP = 5'h0A;
	localparam logic [4:0] CYC_SWAPSTK = 5'h10;
	localparam logic [4:0] CYC_HLTOSP = 5'h06;
	localparam logic [4:0] PH_ACC1 = 5'h02;
	localparam logic [4:0] PH_ACC2 = 5'h03;
	localparam logic [4:0] PH_CAP1 = 5'h03;
	localparam logic [4:0] PH_CAP2 = 5'h04;
	localparam logic [4:0] PH_WR1 = 5'h05;
	localparam logic [4:0] PH_WR2 = 5'h06;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [15:0] RST_SP = 16'h0000;
endpackage : mlsd_pkg

module mlsd_decode (
	input wire logic [7:0] i_opcode,
	output mlsd_pkg::mlsd_kind_t o_kind,
	output logic [4:0] o_cycles
);
	wire [2:0] dst_w = i_opcode[5:3];
	wire [2:0] src_w = i_opcode[2:0];
	wire is_move_w = (i_opcode[7:6] == 2'h1) && (i_opcode != mlsd_pkg::OP_HALT);
	wire is_ld16_w = (i_opcode[7:6] == 2'h0) && (i_opcode[3:0] == 4'h1);
	wire is_stk_w = (i_opcode[7:6] == 2'h3);

	assign o_kind = is_move_w && (dst_w == mlsd_pkg::REG_MEM) ? mlsd_pkg::K_MEMWR :
		is_move_w && (src_w == mlsd_pkg::REG_MEM) ? mlsd_pkg::K_MEMRD :
		is_move_w ? mlsd_pkg::K_COPY :
		is_ld16_w && (i_opcode[5:4] == mlsd_pkg::PAIR_SP_AF) ? mlsd_pkg::K_LDSP :
		is_ld16_w ? mlsd_pkg::K_LDPAIR :
		is_stk_w && (i_opcode[3:0] == 4'h5) ? mlsd_pkg::K_PUSH :
		is_stk_w && (i_opcode[3:0] == 4'h1) ? mlsd_pkg::K_POP :
		(i_opcode == mlsd_pkg::OP_SWAPDH) ? mlsd_pkg::K_SWAPDH :
		(i_opcode == mlsd_pkg::OP_SWAPSTK) ? mlsd_pkg::K_SWAPSTK :
		(i_opcode == mlsd_pkg::OP_HLTOSP) ? mlsd_pkg::K_HLTOSP : mlsd_pkg::K_NONE;

	assign o_cycles = (o_kind == mlsd_pkg::K_COPY) ? mlsd_pkg::CYC_COPY :
		(o_kind == mlsd_pkg::K_MEMRD || o_kind == mlsd_pkg::K_MEMWR) ? mlsd_pkg::CYC_MEM :
		(o_kind == mlsd_pkg::K_LDPAIR || o_kind == mlsd_pkg::K_LDSP) ? mlsd_pkg::CYC_LOAD16 :
		(o_kind == mlsd_pkg::K_SWAPDH) ? mlsd_pkg::CYC_SWAPDH :
		(o_kind == mlsd_pkg::K_PUSH) ? mlsd_pkg::CYC_PUSH :
		(o_kind == mlsd_pkg::K_POP) ? mlsd_pkg::CYC_POP :
		(o_kind == mlsd_pkg::K_SWAPSTK) ? mlsd_pkg::CYC_SWAPSTK :
		(o_kind == mlsd_pkg::K_HLTOSP) ? mlsd_pkg::CYC_HLTOSP : 5'h00;
endmodule : mlsd_decode
`default_nettype wire

//--- rtl/mlsd_core.sv
// Purpose: Execution of the move, load and stack instruction group
// Assumes: Memory returns read data one cycle after the read strobe
// Notes: Register updates land in the last busy cycle
`timescale 1ns/10ps
`default_nettype none

module mlsd_core (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire logic [7:0] i_opcode,
	input wire logic [15:0] i_imm16,
	input wire logic [7:0] i_mem_rdata,
	output logic o_busy,
	output logic o_done,
	output logic o_reject,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [15:0] o_mem_addr,
	output logic [7:0] o_mem_wdata,
	output logic [15:0] o_pair_bc,
	output logic [15:0] o_pair_de,
	output logic [15:0] o_pair_hl,
	output logic [15:0] o_sp,
	output logic [7:0] o_acc,
	output logic [7:0] o_flags
);
	// ----------------------------------------
	// Decode and state
	// ----------------------------------------
	mlsd_pkg::mlsd_kind_t dec_kind_w;
	logic [4:0] dec_cyc_w;
	mlsd_decode u_decode (
		.i_opcode(i_opcode),
		.o_kind(dec_kind_w),
		.o_cycles(dec_cyc_w)
	);

	mlsd_pkg::mlsd_state_t state_q;
	mlsd_pkg::mlsd_kind_t kind_q;
	logic [4:0] cyc_q, phase_q, phase_d;
	logic [2:0] dst_q, src_q;
	logic [1:0] pair_q;
	logic [15:0] imm_q, sp_q;
	logic [7:0] lo_q, hi_q;
	logic [7:0] regs_q [8];
	logic done_q, reject_q, rd_q, wr_q;
	logic [15:0] addr_q;
	logic [7:0] wdata_q;

	function automatic logic [2:0] hi_idx(input logic [1:0] pair);
		hi_idx = (pair == mlsd_pkg::PAIR_SP_AF) ? mlsd_pkg::REG_A : {pair, 1'b0};
	endfunction : hi_idx

	function automatic logic [2:0] lo_idx(input logic [1:0] pair);
		lo_idx = (pair == mlsd_pkg::PAIR_SP_AF) ? mlsd_pkg::REG_FLAGS : {pair, 1'b1};
	endfunction : lo_idx

	wire run_w = (state_q == mlsd_pkg::ST_RUN);
	wire take_w = !run_w && i_start && (dec_kind_w != mlsd_pkg::K_NONE);
	wire last_w = run_w && (phase_q == cyc_q);
	assign phase_d = take_w ? 5'h01 : (run_w && !last_w) ? phase_q + 5'h01 : 5'h00;
	wire [15:0] hl_w = {regs_q[mlsd_pkg::REG_H], regs_q[mlsd_pkg::REG_L]};
	wire [2:0] hi_w = hi_idx(pair_q);
	wire [2:0] lo_w = lo_idx(pair_q);
	wire first_w = (phase_d == mlsd_pkg::PH_ACC1);
	wire second_w = (phase_d == mlsd_pkg::PH_ACC2);

	// ----------------------------------------
	// Memory strobe selection
	// ----------------------------------------
	wire is_rdpair_w = (kind_q == mlsd_pkg::K_POP) || (kind_q == mlsd_pkg::K_SWAPSTK);
	wire stk_wr1_w = (kind_q == mlsd_pkg::K_SWAPSTK) && (phase_d == mlsd_pkg::PH_WR1);
	wire stk_wr2_w = (kind_q == mlsd_pkg::K_SWAPSTK) && (phase_d == mlsd_pkg::PH_WR2);
	wire rd_d = run_w && (((kind_q == mlsd_pkg::K_MEMRD) && first_w) || (is_rdpair_w && (first_w || second_w)));
	wire wr_d = run_w && (((kind_q == mlsd_pkg::K_MEMWR) && first_w) ||
		((kind_q == mlsd_pkg::K_PUSH) && (first_w || second_w)) || stk_wr1_w || stk_wr2_w);
	wire [15:0] addr_d = ((kind_q == mlsd_pkg::K_MEMRD) || (kind_q == mlsd_pkg::K_MEMWR)) ? hl_w :
		(kind_q == mlsd_pkg::K_PUSH) ? (first_w ? sp_q - 16'h0001 : sp_q - 16'h0002) :
		(second_w || stk_wr1_w) ? sp_q + 16'h0001 : sp_q;
	wire [7:0] wdata_d = (kind_q == mlsd_pkg::K_MEMWR) ? regs_q[src_q] :
		(kind_q == mlsd_pkg::K_PUSH) ? (first_w ? regs_q[hi_w] : regs_q[lo_w]) :
		stk_wr1_w ? regs_q[mlsd_pkg::REG_H] : regs_q[mlsd_pkg::REG_L];

	// ----------------------------------------
	// Control and bus flops
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			state_q <= mlsd_pkg::ST_IDLE;
			phase_q <= 5'h00;
			done_q <= 1'b0;
			reject_q <= 1'b0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
		end else begin
			state_q <= (take_w || (run_w && !last_w)) ? mlsd_pkg::ST_RUN : mlsd_pkg::ST_IDLE;
			phase_q <= phase_d;
			done_q <= run_w && !last_w && (phase_d == cyc_q);
			reject_q <= !run_w && i_start && (dec_kind_w == mlsd_pkg::K_NONE);
			rd_q <= rd_d;
			wr_q <= wr_d;
			if (rd_d || wr_d) begin
				addr_q <= addr_d;
			end
			if (wr_d) begin
				wdata_q <= wdata_d;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			kind_q <= mlsd_pkg::K_NONE;
			cyc_q <= 5'h00;
			dst_q <= 3'h0;
			src_q <= 3'h0;
			pair_q <= 2'h0;
			imm_q <= 16'h0000;
			lo_q <= 8'h00;
			hi_q <= 8'h00;
		end else begin
			if (take_w) begin
				kind_q <= dec_kind_w;
				cyc_q <= dec_cyc_w;
				dst_q <= i_opcode[5:3];
				src_q <= i_opcode[2:0];
				pair_q <= i_opcode[5:4];
				imm_q <= i_imm16;
			end
			if (run_w && (phase_q == mlsd_pkg::PH_CAP1)) begin
				lo_q <= i_mem_rdata;
			end
			if (run_w && (phase_q == mlsd_pkg::PH_CAP2)) begin
				hi_q <= i_mem_rdata;
			end
		end
	end

	// ----------------------------------------
	// Register file update at the last cycle
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			for (int i = 0; i < 8; i++) begin
				regs_q[i] <= mlsd_pkg::RST_REG;
			end
			sp_q <= mlsd_pkg::RST_SP;
		end else if (last_w) begin
			unique case (kind_q)
				mlsd_pkg::K_COPY: regs_q[dst_q] <= regs_q[src_q];
				mlsd_pkg::K_MEMRD: regs_q[dst_q] <= lo_q;
				mlsd_pkg::K_LDPAIR: begin
					regs_q[hi_w] <= imm_q[15:8];
					regs_q[lo_w] <= imm_q[7:0];
				end
				mlsd_pkg::K_LDSP: sp_q <= imm_q;
				mlsd_pkg::K_SWAPDH: begin
					regs_q[mlsd_pkg::REG_D] <= regs_q[mlsd_pkg::REG_H];
					regs_q[mlsd_pkg::REG_E] <= regs_q[mlsd_pkg::REG_L];
					regs_q[mlsd_pkg::REG_H] <= regs_q[mlsd_pkg::REG_D];
					regs_q[mlsd_pkg::REG_L] <= regs_q[mlsd_pkg::REG_E];
				end
				mlsd_pkg::K_PUSH: sp_q <= sp_q - 16'h0002;
				mlsd_pkg::K_POP: begin
					regs_q[hi_w] <= hi_q;
					regs_q[lo_w] <= lo_q;
					sp_q <= sp_q + 16'h0002;
				end
				mlsd_pkg::K_SWAPSTK: begin
					regs_q[mlsd_pkg::REG_H] <= hi_q;
					regs_q[mlsd_pkg::REG_L] <= lo_q;
				end
				mlsd_pkg::K_HLTOSP: sp_q <= hl_w;
				default: sp_q <= sp_q;
			endcase
		end
	end

	assign o_busy = (state_q == mlsd_pkg::ST_RUN);
	assign o_done = done_q;
	assign o_reject = reject_q;
	assign o_mem_rd = rd_q;
	assign o_mem_wr = wr_q;
	assign o_mem_addr = addr_q;
	assign o_mem_wdata = wdata_q;
	assign o_pair_bc = {regs_q[mlsd_pkg::REG_B], regs_q[mlsd_pkg::REG_C]};
	assign o_pair_de = {regs_q[mlsd_pkg::REG_D], regs_q[mlsd_pkg::REG_E]};
	assign o_pair_hl = hl_w;
	assign o_sp = sp_q;
	assign o_acc = regs_q[mlsd_pkg::REG_A];
	assign o_flags = regs_q[mlsd_pkg::REG_FLAGS];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_copy_timing: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(o_busy) && kind_q == mlsd_pkg::K_COPY |-> !o_done [*3] ##1 o_done ##1 !o_busy)
		else $error("copy length wrong");
	a_memrd_addr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(o_busy) && kind_q == mlsd_pkg::K_MEMRD |-> ##1 (o_mem_rd && o_mem_addr == o_pair_hl) ##5 o_done)
		else $error("memory read move wrong");
	a_memwr_data: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_mem_wr && kind_q == mlsd_pkg::K_MEMWR |-> o_mem_addr == o_pair_hl && o_mem_wdata == regs_q[src_q])
		else $error("memory write move wrong");
	a_ldpair_load: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(o_busy) && kind_q == mlsd_pkg::K_LDPAIR && pair_q == 2'h0 |-> ##9 o_done ##1 o_pair_bc == imm_q)
		else $error("pair immediate wrong");
	a_ldsp_load: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(o_busy) && kind_q == mlsd_pkg::K_LDSP |-> ##9 o_done ##1 o_sp == imm_q)
		else $error("stack pointer immediate wrong");
	a_swap_pairs: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_done && kind_q == mlsd_pkg::K_SWAPDH |=> o_pair_de == $past(o_pair_hl) && o_pair_hl == $past(o_pair_de))
		else $error("pair swap wrong");
	a_push_order: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(o_busy) && kind_q == mlsd_pkg::K_PUSH |-> ##1 (o_mem_wr && o_mem_addr == o_sp - 16'h0001)
		##1 (o_mem_wr && o_mem_addr == o_sp - 16'h0002) ##9 o_done)
		else $error("push sequence wrong");
	a_push_acc: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_mem_wr && kind_q == mlsd_pkg::K_PUSH && pair_q == 2'h3 |-> o_mem_wdata == (phase_q == mlsd_pkg::PH_ACC1 ? o_acc : o_flags))
		else $error("accumulator push data wrong");
	a_pop_timing: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(o_busy) && kind_q == mlsd_pkg::K_POP |-> ##1 (o_mem_rd && o_mem_addr == o_sp) ##8 o_done ##1 o_sp == $past(o_sp, 10) + 16'h0002)
		else $error("pop sequence wrong");
	a_pop_acc: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_done && kind_q == mlsd_pkg::K_POP && pair_q == 2'h3 |=> o_acc == $past(hi_q) && o_flags == $past(lo_q))
		else $error("accumulator pop wrong");
	a_stack_swap: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(o_busy) && kind_q == mlsd_pkg::K_SWAPSTK |-> ##4 (o_mem_wr && o_mem_wdata == o_pair_hl[15:8]) ##11 o_done)
		else $error("stack top swap wrong");
	a_hl_to_sp: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(o_busy) && kind_q == mlsd_pkg::K_HLTOSP |-> ##5 o_done ##1 o_sp == o_pair_hl)
		else $error("HL to stack pointer wrong");
endmodule : mlsd_core
`default_nettype wire

//--- testbench/mlsd_mem_model.sv
// Purpose: Byte memory on the far side of the move, load and stack core
// Assumes: Read data is due in the cycle after the read strobe
// Notes: Outside that cycle the data lines toggle every cycle
`timescale 1ns/10ps
`default_nettype none

module mlsd_mem_model (
	input wire logic i_clk_sys,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:65535];

	initial begin
		o_rdata = 8'h00;
		for (int a = 0; a < 65536; a++) begin
			mem[a] = 8'h00;
		end
	end

	// Stale data never repeats the last byte
	always @(posedge i_clk_sys) begin
		if (i_wr) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
	end
endmodule : mlsd_mem_model
`default_nettype wire

//--- testbench/move_load_stack_decoder_test.sv
// Purpose: Self-checking bench for the move, load and stack core
// Assumes: One-cycle memory model on the far side
// Notes: Expected registers kept in r, flag byte in slot 6
`timescale 1ns/10ps
`default_nettype none

module move_load_stack_decoder_test;
	// --------------------------------
	// Harness
	// --------------------------------
	logic i_clk_sys = 1'b0;
	logic i_nrst = 1'b0;
	logic i_start = 1'b0;
	logic [7:0] i_opcode = 8'h00;
	logic [15:0] i_imm16 = 16'h0000;
	logic [7:0] i_mem_rdata;
	logic o_busy, o_done, o_reject, o_mem_rd, o_mem_wr;
	logic [15:0] o_mem_addr, o_pair_bc, o_pair_de, o_pair_hl, o_sp;
	logic [7:0] o_mem_wdata, o_acc, o_flags;
	logic [7:0] r [0:7] = '{default: 8'h00};
	logic [15:0] sp = 16'h0000;
	int n_fail = 0;
	int cmp_count = 0;

	always #20 i_clk_sys = ~i_clk_sys;

	mlsd_core dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_start(i_start), .i_opcode(i_opcode),
		.i_imm16(i_imm16), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_done(o_done),
		.o_reject(o_reject), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
		.o_mem_wdata(o_mem_wdata), .o_pair_bc(o_pair_bc), .o_pair_de(o_pair_de),
		.o_pair_hl(o_pair_hl), .o_sp(o_sp), .o_acc(o_acc), .o_flags(o_flags));

	mlsd_mem_model mem_u (.i_clk_sys(i_clk_sys), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

	function automatic int hi_i(input int p);
		return (p == 3) ? 7 : 2 * p;
	endfunction : hi_i

	function automatic int lo_i(input int p);
		return (p == 3) ? 6 : 2 * p + 1;
	endfunction : lo_i

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic check_regs;
		chk("bc", {r[0], r[1]}, o_pair_bc);
		chk("de", {r[2], r[3]}, o_pair_de);
		chk("hl", {r[4], r[5]}, o_pair_hl);
		chk("acc", {8'h00, r[7]}, {8'h00, o_acc});
		chk("flags", {8'h00, r[6]}, {8'h00, o_flags});
		chk("sp", sp, o_sp);
	endtask : check_regs

	// Start held into busy with an unknown opcode, which must be ignored
	task automatic run_op(input logic [7:0] op, input logic [15:0] imm, input logic [4:0] ncyc);
		int n;
		int k;
		n = 1;
		k = 0;
		i_start = 1'b1;
		i_opcode = op;
		i_imm16 = imm;
		@(posedge i_clk_sys);
		#1;
		i_opcode = 8'h76;
		while (o_done !== 1'b1) begin
			if (o_busy === 1'b1)
				n++;
			chk("reject while busy", 16'h0000, {15'h0000, o_reject});
			if (k == 1)
				i_start = 1'b0;
			if (k == 40) begin
				n_fail++;
				give_verdict();
			end
			@(posedge i_clk_sys);
			#1;
			k++;
		end
		i_start = 1'b0;
		chk("busy at done", 16'h0001, {15'h0000, o_busy});
		chk("cycles", {11'h000, ncyc}, n[15:0]);
		@(posedge i_clk_sys);
		#1;
		chk("busy after", 16'h0000, {15'h0000, o_busy});
	endtask : run_op

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_reject;
		logic [7:0] ops [3] = '{8'h76, 8'h02, 8'h36};
		foreach (ops[i]) begin
			i_start = 1'b1;
			i_opcode = ops[i];
			@(posedge i_clk_sys);
			#1;
			i_start = 1'b0;
			chk("reject pulse", 16'h0001, {15'h0000, o_reject});
			chk("busy on reject", 16'h0000, {15'h0000, o_busy});
			@(posedge i_clk_sys);
			#1;
			chk("reject end", 16'h0000, {15'h0000, o_reject});
		end
		check_regs();
		$display("test reject done");
	endtask : t_reject

	task automatic t_load;
		logic [15:0] v [4] = '{16'h1234, 16'h5678, 16'h9ABC, 16'h0200};
		for (int p = 0; p < 4; p++) begin
			run_op({2'b00, p[1:0], 4'h1}, v[p], 5'h0A);
			if (p == 3)
				sp = v[p];
			else
				{r[2 * p], r[2 * p + 1]} = v[p];
			check_regs();
		end
		$display("test load done");
	endtask : t_load

	task automatic t_copy;
		int s;
		for (int d = 0; d < 8; d++) begin
			s = (d + 3) % 8;
			if (d != 6 && s != 6) begin
				run_op({2'b01, d[2:0], s[2:0]}, 16'h0000, 5'h04);
				r[d] = r[s];
				check_regs();
			end
		end
		$display("test copy done");
	endtask : t_copy

	task automatic t_mem;
		logic [15:0] hl;
		hl = {r[4], r[5]};
		mem_u.mem[hl] = 8'hA5;
		run_op(8'h5E, 16'h0000, 5'h07);
		r[3] = 8'hA5;
		check_regs();
		run_op(8'h77, 16'h0000, 5'h07);
		chk("mem write", {8'h00, r[7]}, {8'h00, mem_u.mem[hl]});
		check_regs();
		$display("test memory done");
	endtask : t_mem

	task automatic t_swap;
		run_op(8'hEB, 16'h0000, 5'h04);
		{r[2], r[3], r[4], r[5]} = {r[4], r[5], r[2], r[3]};
		check_regs();
		$display("test swap done");
	endtask : t_swap

	task automatic t_stack;
		logic [7:0] lo;
		logic [7:0] hi;
		for (int p = 0; p < 4; p++) begin
			run_op({2'b11, p[1:0], 4'h5}, 16'h0000, 5'h0C);
			sp = sp - 16'h0002;
			chk("push high", {8'h00, r[hi_i(p)]}, {8'h00, mem_u.mem[sp + 16'h0001]});
			chk("push low", {8'h00, r[lo_i(p)]}, {8'h00, mem_u.mem[sp]});
			check_regs();
		end
		for (int p = 0; p < 4; p++) begin
			lo = mem_u.mem[sp];
			hi = mem_u.mem[sp + 16'h0001];
			run_op({2'b11, p[1:0], 4'h1}, 16'h0000, 5'h0A);
			r[lo_i(p)] = lo;
			r[hi_i(p)] = hi;
			sp = sp + 16'h0002;
			check_regs();
		end
		$display("test stack done");
	endtask : t_stack

	task automatic t_swap_stack;
		mem_u.mem[sp] = 8'h3C;
		mem_u.mem[sp + 16'h0001] = 8'hC3;
		run_op(8'hE3, 16'h0000, 5'h10);
		chk("stack low", {8'h00, r[5]}, {8'h00, mem_u.mem[sp]});
		chk("stack high", {8'h00, r[4]}, {8'h00, mem_u.mem[sp + 16'h0001]});
		r[5] = 8'h3C;
		r[4] = 8'hC3;
		check_regs();
		$display("test stack swap done");
	endtask : t_swap_stack

	task automatic t_hl_to_stack_pointer_op;
		run_op(8'hF9, 16'h0000, 5'h06);
		sp = {r[4], r[5]};
		check_regs();
		$display("test stack pointer copy done");
	endtask : t_hl_to_stack_pointer_op

	initial begin
		repeat (3) @(posedge i_clk_sys);
		#1;
		check_regs();
		i_nrst = 1'b1;
		@(posedge i_clk_sys);
		#1;
		t_reject();
		t_load();
		t_copy();
		t_mem();
		t_swap();
		t_stack();
		t_swap_stack();
		t_hl_to_stack_pointer_op();
		give_verdict();
	end
endmodule : move_load_stack_decoder_test
`default_nettype wire
